//--- pkg/acbp_pkg.sv
// constants and carriers for the single-wire block framer
// assumes a 20 MHz core clock and a separate line decoder
package acbp_pkg;
  localparam logic [7:0]  FLAG_CMD    = 8'h66;
  localparam logic [7:0]  FLAG_TX     = 8'h99;
  localparam logic [7:0]  FLAG_SLEEP  = 8'hCC;
  localparam logic [7:0]  ST_WAKE     = 8'h11;
  localparam logic [7:0]  ST_EXEC_ERR = 8'h0F;
  localparam logic [7:0]  ST_COMM_ERR = 8'hFF;
  localparam logic [7:0]  RESP_CNT    = 8'h04;
  localparam logic [15:0] CRC_POLY    = 16'h8005;
  localparam logic [15:0] CRC_INIT    = 16'h0000;
  localparam logic [7:0]  CNT_MIN     = 8'h04;
  localparam logic [7:0]  CNT_MAX     = 8'h27;
  // opcodes and their fixed block lengths
  localparam logic [7:0]  OP_H0       = 8'h08;
  localparam logic [7:0]  OP_H1       = 8'h40;
  localparam logic [7:0]  OP_H2       = 8'h80;
  localparam logic [5:0]  LEN_H0      = 6'h27;
  localparam logic [5:0]  LEN_H1      = 6'h14;
  localparam logic [5:0]  LEN_H2      = 6'h27;
  // byte positions inside a block
  localparam logic [5:0]  IDX_CNT     = 6'h00;
  localparam logic [5:0]  IDX_OP      = 6'h01;
  localparam logic [5:0]  IDX_A1      = 6'h02;
  localparam logic [5:0]  IDX_A2L     = 6'h03;
  localparam logic [5:0]  IDX_A2H     = 6'h04;
  localparam logic [1:0]  TXI_CNT     = 2'h0;
  localparam logic [1:0]  TXI_PKT     = 2'h1;
  localparam logic [1:0]  TXI_CRCL    = 2'h2;
  localparam logic [1:0]  TXI_CRCH    = 2'h3;
  // timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int PARSE_DELAY_NS  = 100000;
  localparam int PARSE_CYC       = PARSE_DELAY_NS / CLK_PERIOD_NS;
  localparam int IO_TIMEOUT_US   = 1500;
  localparam int IO_TIMEOUT_CYC  = IO_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int FAILSAFE_MS     = 1700;
  localparam int FAILSAFE_CYC    = FAILSAFE_MS * 1000 / CLK_PERIOD_NS * 1000;

  typedef enum logic [5:0] {
    S_SLEEP = 6'h01,
    S_IDLE  = 6'h02,
    S_RX    = 6'h04,
    S_PARSE = 6'h08,
    S_EXEC  = 6'h10,
    S_TX    = 6'h20
  } acbp_state_t;

  typedef struct packed {
    logic wake;
    logic one;
    logic zero;
    logic lead;
    logic bad;
  } acbp_tok_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  arg1;
    logic [15:0] arg2;
  } acbp_cmd_t;
endpackage

//--- verilog/acbp_framer.sv
// block layer of the single-wire host: flags, framing, crc, timeouts
// assumes decoded tokens and tx_ready come from logic on the same clock
//
// Summary of operation
// - first byte is total block count
// - crc-16 poly 8005, zero init, checked
// - crc low byte first, high byte last
// - after wake, transmit returns 0x11 status
// - transmit ignored while busy, last answer resent otherwise
// - token remainder within timeout else sleep
// - timeout armed over block, restarts per data bit
// - timeout armed at wake, idle means sleep
// - timeout disabled during execution
// - failsafe counter from wake forces sleep
// - data bit while asleep acts as wake
// - bytes move lsb first, arrays in order
// - opcode, first_argument, second_argument, data layout
// - receive fault: no execution, answer 0xFF
// - bad opcode or argument: answer 0x0F
// - wrong length per opcode: skip, report error
// - output block after execution completes
// - flags 66 command, 99 transmit, CC sleep
// - sleep flag resets engine and buffer
// - status blocks are four bytes long
`timescale 1ns/1ps
module acbp_framer #(
  parameter int IOW            = 16,
  parameter int FSW            = 26,
  parameter int IO_TIMEOUT_CYC = acbp_pkg::IO_TIMEOUT_CYC,
  parameter int FAILSAFE_CYC   = acbp_pkg::FAILSAFE_CYC
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire acbp_pkg::acbp_tok_t tok,
  input  wire logic               tx_ready,
  input  wire logic               exec_done,
  input  wire logic               exec_err,
  input  wire logic [7:0]         exec_result,
  output logic                    tx_valid,
  output logic [7:0]              tx_data,
  output logic                    pkt_valid,
  output logic [7:0]              pkt_byte,
  output logic [5:0]              pkt_index,
  output logic                    cmd_start,
  output acbp_pkg::acbp_cmd_t     cmd,
  output logic                    asleep
);
  localparam logic [IOW-1:0] IO_LAST = IOW'(IO_TIMEOUT_CYC - 1);
  localparam logic [FSW-1:0] FS_LAST = FSW'(FAILSAFE_CYC - 1);
  localparam logic [11:0]    PS_LAST = 12'(acbp_pkg::PARSE_CYC - 1);

  typedef struct packed {
    acbp_pkg::acbp_state_t st;
    logic [7:0]            sh;
    logic [2:0]            nbit;
    logic                  io_arm;
    logic [IOW-1:0]        io_cnt;
    logic [FSW-1:0]        fs_cnt;
    logic [5:0]            idx;
    logic [5:0]            cnt;
    logic [15:0]           crc;
    logic                  err_comm;
    acbp_pkg::acbp_cmd_t   cmd;
    logic [11:0]           pcnt;
    logic                  resp_vld;
    logic [7:0]            resp_byte;
    logic [1:0]            tx_idx;
    logic [15:0]           tx_crc;
    logic [7:0]            head;
    logic [7:0]            tail;
    logic                  hv;
    logic                  tv;
    logic                  pkt_vld;
    logic [7:0]            pkt_byte;
    logic [5:0]            pkt_idx;
    logic                  cmd_start;
  } acbp_regs_t;

  localparam acbp_regs_t RST_REGS = '{st: acbp_pkg::S_SLEEP, default: '0};

  acbp_regs_t q;
  acbp_regs_t d;
  logic       bit_tok;
  logic [7:0] nb;
  logic       byte_done;
  logic       listen;

  // serial update, data bits fed lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i] ^ r[15])
        r = (r << 1) ^ acbp_pkg::CRC_POLY;
      else
        r = r << 1;
    end
    return r;
  endfunction

  function automatic logic [5:0] op_len(input logic [7:0] op);
    unique case (op)
      acbp_pkg::OP_H0: return acbp_pkg::LEN_H0;
      acbp_pkg::OP_H1: return acbp_pkg::LEN_H1;
      acbp_pkg::OP_H2: return acbp_pkg::LEN_H2;
      default:         return 6'h00;
    endcase
  endfunction

  function automatic logic args_ok(input acbp_pkg::acbp_cmd_t c);
    if (c.opcode == acbp_pkg::OP_H1)
      return c.arg2 == 16'h0000;
    if (c.opcode == acbp_pkg::OP_H2)
      return (c.arg1 == 8'h00) && (c.arg2 == 16'h0000);
    return 1'b1;
  endfunction

  assign listen    = (q.st == acbp_pkg::S_IDLE) || (q.st == acbp_pkg::S_RX);
  assign bit_tok   = tok.one | tok.zero;
  assign nb        = {tok.one, q.sh[7:1]};
  assign byte_done = listen && bit_tok && (q.nbit == 3'h7);

  always_comb
  begin
    logic       go_sleep;
    logic [7:0] b;
    go_sleep    = 1'b0;
    b           = 8'h00;
    d           = q;
    d.cmd_start = 1'b0;
    d.pkt_vld   = 1'b0;
    // drain side of the two-entry output buffer
    if (tx_ready && q.hv)
    begin
      if (q.tv)
      begin
        d.head = q.tail;
        d.tv   = 1'b0;
      end
      else
        d.hv = 1'b0;
    end
    if (q.st != acbp_pkg::S_SLEEP)
    begin
      d.fs_cnt = q.fs_cnt + 1'b1;
      if (q.fs_cnt == FS_LAST)
        go_sleep = 1'b1;
    end
    // gap timer only runs while listening
    if (listen && q.io_arm)
    begin
      d.io_cnt = q.io_cnt + 1'b1;
      if (q.io_cnt == IO_LAST)
        go_sleep = 1'b1;
    end
    if (listen)
    begin
      if (tok.lead || tok.bad)
        d.io_arm = 1'b1;
      if (bit_tok)
      begin
        d.sh     = nb;
        d.nbit   = q.nbit + 1'b1;
        d.io_cnt = '0;
      end
    end
    unique case (q.st)
      acbp_pkg::S_SLEEP:
      begin
        // a wake token or data bit wakes; decoder drops bits during wake-up delay
        if (tok.wake || bit_tok)
        begin
          d.st        = acbp_pkg::S_IDLE;
          d.io_arm    = 1'b1;
          d.io_cnt    = '0;
          d.fs_cnt    = '0;
          d.resp_vld  = 1'b1;
          d.resp_byte = acbp_pkg::ST_WAKE;
        end
      end
      acbp_pkg::S_IDLE:
      begin
        if (byte_done)
        begin
          d.io_arm = 1'b0;
          unique case (nb)
            acbp_pkg::FLAG_CMD:
            begin
              d.st       = acbp_pkg::S_RX;
              d.io_arm   = 1'b1;
              d.idx      = acbp_pkg::IDX_CNT;
              d.crc      = acbp_pkg::CRC_INIT;
              d.err_comm = 1'b0;
              d.cmd      = '0;
            end
            acbp_pkg::FLAG_TX:
            begin
              if (q.resp_vld)
              begin
                d.st     = acbp_pkg::S_TX;
                d.tx_idx = acbp_pkg::TXI_CNT;
                d.tx_crc = crc_byte(crc_byte(acbp_pkg::CRC_INIT, acbp_pkg::RESP_CNT),
                                    q.resp_byte);
              end
            end
            acbp_pkg::FLAG_SLEEP: go_sleep = 1'b1;
            default: ;
          endcase
        end
      end
      acbp_pkg::S_RX:
      begin
        if (byte_done)
        begin
          d.idx = q.idx + 1'b1;
          if (q.idx == acbp_pkg::IDX_CNT)
          begin
            d.cnt = nb[5:0];
            d.crc = crc_byte(q.crc, nb);
            // out-of-range count ends the block at once as a fault
            if (nb < acbp_pkg::CNT_MIN || nb > acbp_pkg::CNT_MAX)
            begin
              d.err_comm = 1'b1;
              d.st       = acbp_pkg::S_PARSE;
              d.pcnt     = '0;
              d.io_arm   = 1'b0;
            end
          end
          else if (q.idx < q.cnt - 6'h02)
          begin
            d.crc = crc_byte(q.crc, nb);
            unique case (q.idx)
              acbp_pkg::IDX_OP:  d.cmd.opcode     = nb;
              acbp_pkg::IDX_A1:  d.cmd.arg1       = nb;
              acbp_pkg::IDX_A2L: d.cmd.arg2[7:0]  = nb;
              acbp_pkg::IDX_A2H: d.cmd.arg2[15:8] = nb;
              default:
              begin
                d.pkt_vld  = 1'b1;
                d.pkt_byte = nb;
                d.pkt_idx  = q.idx - 6'h01;
              end
            endcase
          end
          else if (q.idx == q.cnt - 6'h02)
          begin
            if (nb != q.crc[7:0])
              d.err_comm = 1'b1;
          end
          else
          begin
            if (nb != q.crc[15:8])
              d.err_comm = 1'b1;
            d.st     = acbp_pkg::S_PARSE;
            d.pcnt   = '0;
            d.io_arm = 1'b0;
          end
        end
      end
      acbp_pkg::S_PARSE:
      begin
        d.pcnt = q.pcnt + 1'b1;
        if (q.pcnt == PS_LAST)
        begin
          d.st        = acbp_pkg::S_IDLE;
          d.resp_vld  = 1'b1;
          d.nbit      = 3'h0;
          if (q.err_comm)
            d.resp_byte = acbp_pkg::ST_COMM_ERR;
          else if (op_len(q.cmd.opcode) == 6'h00 || !args_ok(q.cmd))
            d.resp_byte = acbp_pkg::ST_EXEC_ERR;
          else if (op_len(q.cmd.opcode) != q.cnt)
            d.resp_byte = acbp_pkg::ST_COMM_ERR;
          else
          begin
            d.st        = acbp_pkg::S_EXEC;
            d.resp_vld  = 1'b0;
            d.cmd_start = 1'b1;
          end
        end
      end
      acbp_pkg::S_EXEC:
      begin
        // tokens ignored and gap timer idle while busy
        d.io_arm = 1'b0;
        if (exec_done)
        begin
          d.st        = acbp_pkg::S_IDLE;
          d.nbit      = 3'h0;
          d.resp_vld  = 1'b1;
          d.resp_byte = exec_err ? acbp_pkg::ST_EXEC_ERR : exec_result;
        end
      end
      acbp_pkg::S_TX:
      begin
        if (!q.tv)
        begin
          unique case (q.tx_idx)
            acbp_pkg::TXI_CNT:  b = acbp_pkg::RESP_CNT;
            acbp_pkg::TXI_PKT:  b = q.resp_byte;
            acbp_pkg::TXI_CRCL: b = q.tx_crc[7:0];
            acbp_pkg::TXI_CRCH: b = q.tx_crc[15:8];
          endcase
          if (!d.hv)
          begin
            d.head = b;
            d.hv   = 1'b1;
          end
          else
          begin
            d.tail = b;
            d.tv   = 1'b1;
          end
          d.tx_idx = q.tx_idx + 1'b1;
          if (q.tx_idx == acbp_pkg::TXI_CRCH)
          begin
            d.st   = acbp_pkg::S_IDLE;
            d.nbit = 3'h0;
          end
        end
      end
    endcase
    if (go_sleep)
      d = RST_REGS;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      q <= RST_REGS;
    else if (clk_en)
      q <= d;
  end

  assign tx_valid  = q.hv;
  assign tx_data   = q.head;
  assign pkt_valid = q.pkt_vld;
  assign pkt_byte  = q.pkt_byte;
  assign pkt_index = q.pkt_idx;
  assign cmd_start = q.cmd_start;
  assign cmd       = q.cmd;
  assign asleep    = q.st[0];

  a_wake_status: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st == acbp_pkg::S_SLEEP && clk_en && tok.wake) |=>
    (q.st == acbp_pkg::S_IDLE && q.resp_vld && q.resp_byte == acbp_pkg::ST_WAKE))
    else $error("wake did not load status 0x11");

  a_crc_high_last: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st == acbp_pkg::S_TX && clk_en && !q.tv && q.tx_idx == acbp_pkg::TXI_CRCH) |=>
    ((q.tv ? q.tail : q.head) == $past(q.tx_crc[15:8]) && q.st == acbp_pkg::S_IDLE))
    else $error("last block byte is not crc high");

  a_parse_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st == acbp_pkg::S_PARSE && clk_en && q.pcnt < PS_LAST && q.fs_cnt != FS_LAST) |=>
    (q.st == acbp_pkg::S_PARSE && !q.resp_vld || q.st == acbp_pkg::S_PARSE && $stable(q.resp_vld)))
    else $error("left parse before the parse delay");

  a_comm_error: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st == acbp_pkg::S_PARSE && clk_en && q.pcnt == PS_LAST && q.err_comm
     && q.fs_cnt != FS_LAST) |=>
    (q.resp_byte == acbp_pkg::ST_COMM_ERR && !q.cmd_start && q.st == acbp_pkg::S_IDLE))
    else $error("receive fault not answered with 0xFF");

  a_bad_opcode: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st == acbp_pkg::S_PARSE && clk_en && q.pcnt == PS_LAST && !q.err_comm
     && op_len(q.cmd.opcode) == 6'h00 && q.fs_cnt != FS_LAST) |=>
    (q.resp_byte == acbp_pkg::ST_EXEC_ERR && q.resp_vld))
    else $error("unknown opcode not answered with 0x0F");

  a_len_error: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st == acbp_pkg::S_PARSE && clk_en && q.pcnt == PS_LAST && !q.err_comm
     && op_len(q.cmd.opcode) != 6'h00 && op_len(q.cmd.opcode) != q.cnt
     && q.fs_cnt != FS_LAST) |=> (!q.cmd_start && q.st == acbp_pkg::S_IDLE))
    else $error("wrong block length was executed");

  a_exec_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st == acbp_pkg::S_EXEC && clk_en && !exec_done && q.fs_cnt != FS_LAST) |=>
    (q.st == acbp_pkg::S_EXEC && !q.io_arm))
    else $error("busy state left without completion");

  a_exec_output: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st == acbp_pkg::S_EXEC && clk_en && exec_done && !exec_err && q.fs_cnt != FS_LAST)
    |=> (q.resp_vld && q.resp_byte == $past(exec_result)))
    else $error("execution result not offered");

  a_sleep_flag: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st == acbp_pkg::S_IDLE && clk_en && byte_done && nb == acbp_pkg::FLAG_SLEEP) |=>
    (q.st == acbp_pkg::S_SLEEP && !q.hv && !q.resp_vld))
    else $error("sleep flag did not reset the block");

  a_failsafe: assert property (@(posedge clock) disable iff (sys_rst)
    (q.st != acbp_pkg::S_SLEEP && clk_en && q.fs_cnt == FS_LAST) |=>
    (q.st == acbp_pkg::S_SLEEP))
    else $error("failsafe expiry did not force sleep");

  a_io_timeout: assert property (@(posedge clock) disable iff (sys_rst)
    (listen && q.io_arm && clk_en && q.io_cnt == IO_LAST) |=> (q.st == acbp_pkg::S_SLEEP))
    else $error("gap timeout did not force sleep");
endmodule

//--- bench/acbp_ctrl_model.sv
// controller side of the framer: sends decoded tokens, accepts tx bytes
// assumes the framer samples tok and tx_ready on the rising clock edge
`timescale 1ns/1ps
module acbp_ctrl_model (
  input  wire logic           clock,
  output acbp_pkg::acbp_tok_t tok,
  output logic                tx_ready
);
  logic [2:0] cnt_q = 3'h0;

  initial tok = '0;

  // stalls three cycles in eight, so the two-entry buffer fills up
  always @(negedge clock)
    cnt_q <= cnt_q + 3'h1;
  assign tx_ready = (cnt_q > 3'h2);

  task automatic pulse(input logic [4:0] t, input int gap);
    int i;
    begin
      @(negedge clock);
      tok = acbp_pkg::acbp_tok_t'(t);
      @(negedge clock);
      tok = '0;
      for (i = 0; i < gap; i++)
        @(negedge clock);
    end
  endtask

  task automatic wake();
    begin
      pulse(5'h10, 2);
    end
  endtask

  // each bit is a leading edge followed by its decoded value
  task automatic send_byte(input logic [7:0] b);
    int i;
    begin
      for (i = 0; i < 8; i++)
      begin
        pulse(5'h02, 0);
        pulse(b[i] ? 5'h08 : 5'h04, i % 3);
      end
    end
  endtask
endmodule

//--- bench/acbp_framer_tb_top.sv
// self-checking bench for the block framer; bench also plays the engine
// assumes short timeout parameters and a 20 MHz clock
`timescale 1ns/1ps
module acbp_framer_tb_top;
  localparam int IOC = 200;
  localparam int FSC = 12000;
  logic                clock       = 1'b0;
  logic                sys_rst     = 1'b1;
  logic                exec_done   = 1'b0;
  logic                exec_err    = 1'b0;
  logic [7:0]          exec_result = 8'h00;
  acbp_pkg::acbp_tok_t tok;
  acbp_pkg::acbp_cmd_t cmd;
  logic                tx_ready, tx_valid, pkt_valid, cmd_start, asleep;
  logic [7:0]          tx_data, pkt_byte;
  logic [5:0]          pkt_index;
  int                  miscompares     = 0;
  int                  samples_checked = 0;
  int                  seed            = 32'hca4916e8;
  int                  starts          = 0;
  int                  pkts            = 0;
  logic [7:0]          exp_q[$];
  logic [31:0]         cmd_q[$];
  logic [13:0]         pkt_q[$];

  initial forever #25 clock = ~clock;

  acbp_framer #(.IO_TIMEOUT_CYC(IOC), .FAILSAFE_CYC(FSC)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .tok(tok),
    .tx_ready(tx_ready), .exec_done(exec_done), .exec_err(exec_err),
    .exec_result(exec_result), .tx_valid(tx_valid), .tx_data(tx_data),
    .pkt_valid(pkt_valid), .pkt_byte(pkt_byte), .pkt_index(pkt_index),
    .cmd_start(cmd_start), .cmd(cmd), .asleep(asleep));

  acbp_ctrl_model ctrl_u (.clock(clock), .tok(tok), .tx_ready(tx_ready));

  task automatic conclude();
    begin
      $display("checks=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        miscompares++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task automatic timeout();
    begin
      miscompares++;
      $display("[ERR] t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
      conclude();
    end
  endtask

  // a missing note turns into an unknown, so a stray byte always fails
  always @(posedge clock)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        exp_q.push_back(8'hXX);
      chk({24'h0, tx_data}, {24'h0, exp_q.pop_front()});
    end
    if (cmd_start === 1'b1)
    begin
      starts++;
      if (cmd_q.size() == 0)
        cmd_q.push_back(32'hXXXXXXXX);
      chk(cmd, cmd_q.pop_front());
    end
    if (pkt_valid === 1'b1)
    begin
      pkts++;
      if (pkt_q.size() == 0)
        pkt_q.push_back('x);
      chk({18'h0, pkt_index, pkt_byte}, {18'h0, pkt_q.pop_front()});
    end
  end

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    begin
      c = acbp_pkg::CRC_INIT;
      foreach (q[k])
        for (int i = 0; i < 8; i++)
          c = {c[14:0], 1'b0} ^ ((q[k][i] ^ c[15]) ? acbp_pkg::CRC_POLY : 16'h0000);
      return c;
    end
  endfunction

  task automatic expect_resp(input logic [7:0] code);
    logic [15:0] c;
    begin
      c = crc16('{8'h04, code});
      exp_q.push_back(8'h04);
      exp_q.push_back(code);
      exp_q.push_back(c[7:0]);
      exp_q.push_back(c[15:8]);
    end
  endtask

  task automatic cyc(input int n);
    begin
      repeat (n) @(negedge clock);
    end
  endtask

  task automatic drain();
    int n;
    begin
      for (n = 0; n < 2000 && (exp_q.size() > 0 || tx_valid === 1'b1); n++)
        @(negedge clock);
      if (n >= 2000)
        timeout();
    end
  endtask

  task automatic wait_sleep(input int bound, output int n);
    begin
      for (n = 0; n < bound && asleep !== 1'b1; n++)
        @(negedge clock);
      if (n >= bound)
        timeout();
    end
  endtask

  task automatic read_resp(input logic [7:0] code);
    begin
      expect_resp(code);
      ctrl_u.send_byte(acbp_pkg::FLAG_TX);
      drain();
    end
  endtask

  // a reserved flag first, which must draw no reply
  task automatic open_session();
    begin
      ctrl_u.wake();
      chk(asleep, 1'b0);
      ctrl_u.send_byte(8'h5A);
      read_resp(acbp_pkg::ST_WAKE);
    end
  endtask

  task automatic close_session();
    begin
      ctrl_u.send_byte(acbp_pkg::FLAG_SLEEP);
      cyc(2);
      chk(asleep, 1'b1);
    end
  endtask

  task automatic send_cmd(input logic [7:0] len, input logic [7:0] op,
                          input logic [7:0] a1, input logic [15:0] a2,
                          input logic bad);
    logic [7:0]  q[$];
    logic [7:0]  b;
    logic [15:0] c;
    begin
      q = '{len, op, a1, a2[7:0], a2[15:8]};
      while (q.size() < len - 2)
      begin
        b = 8'($random(seed));
        pkt_q.push_back({6'(q.size() - 1), b});
        q.push_back(b);
      end
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      ctrl_u.send_byte(acbp_pkg::FLAG_CMD);
      foreach (q[k])
        ctrl_u.send_byte(q[k]);
    end
  endtask

  task automatic run_good(input logic [7:0] len, input logic [7:0] op,
                          input logic err);
    logic [7:0] a1, r;
    int         s0, n;
    begin
      open_session();
      a1 = (op == acbp_pkg::OP_H2) ? 8'h00 : 8'($random(seed));
      r = 8'($random(seed));
      cmd_q.push_back({op, a1, 16'h0000});
      pkts = 0;
      s0 = starts;
      send_cmd(len, op, a1, 16'h0000, 1'b0);
      for (n = 0; n < 2100 && starts == s0; n++)
        @(negedge clock);
      chk({31'h0, n >= 1990 && n <= 2010}, 32'h1);
      chk(pkts, len - 7);
      ctrl_u.send_byte(acbp_pkg::FLAG_TX);
      cyc(2 * IOC);
      chk(asleep, 1'b0);
      exec_result = r;
      exec_err = err;
      exec_done = 1'b1;
      cyc(1);
      exec_done = 1'b0;
      exec_err = 1'b0;
      read_resp(err ? acbp_pkg::ST_EXEC_ERR : r);
      read_resp(err ? acbp_pkg::ST_EXEC_ERR : r);
      close_session();
    end
  endtask

  // last entry carries a count below the legal minimum
  logic [7:0]  t_len[5] = '{8'h27, 8'h14, 8'h07, 8'h14, 8'h03};
  logic [7:0]  t_op[5]  = '{8'h80, 8'h08, 8'h33, 8'h40, 8'h40};
  logic [15:0] t_a2[5]  = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000};
  logic        t_bad[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic [7:0]  t_res[5] = '{8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'hFF};

  initial
  begin
    int n, s0;
    cyc(4);
    sys_rst = 1'b0;
    chk(asleep, 1'b1);
    run_good({2'h0, acbp_pkg::LEN_H1}, acbp_pkg::OP_H1, 1'b0);
    run_good({2'h0, acbp_pkg::LEN_H2}, acbp_pkg::OP_H2, 1'b1);
    for (int k = 0; k < 5; k++)
    begin
      open_session();
      s0 = starts;
      send_cmd(t_len[k], t_op[k], 8'h00, t_a2[k], t_bad[k]);
      cyc(2010);
      read_resp(t_res[k]);
      chk(starts, s0);
      close_session();
    end
    ctrl_u.wake();
    wait_sleep(IOC + 20, n);
    chk({31'h0, n >= IOC - 10}, 32'h1);
    cyc(2 * IOC);
    open_session();
    ctrl_u.send_byte(acbp_pkg::FLAG_CMD);
    ctrl_u.send_byte(8'h14);
    wait_sleep(IOC + 20, n);
    chk({31'h0, n >= IOC - 10}, 32'h1);
    ctrl_u.pulse(5'h02, 0);
    ctrl_u.pulse(5'h08, 2);
    chk(asleep, 1'b0);
    read_resp(acbp_pkg::ST_WAKE);
    wait_sleep(FSC, n);
    chk({31'h0, n >= FSC - 600}, 32'h1);
    // an illegal token alone must still arm the gap timer
    open_session();
    ctrl_u.pulse(5'h01, 0);
    wait_sleep(IOC + 20, n);
    chk({31'h0, n >= IOC - 10}, 32'h1);
    conclude();
  end
endmodule
